// File: logic/wdcm_consts.svh
`ifndef WDCM_CONSTS_SVH
`define WDCM_CONSTS_SVH

// ========================================
// Register byte offsets
`define WDCM_OFF_SERVICE 8'h00
`define WDCM_OFF_OPTION 8'h04
`define WDCM_OFF_TEST 8'h08
`define WDCM_OFF_STATUS 8'h0C

// ========================================
// Field positions
`define WDCM_OPT_RATE_LO 0
`define WDCM_OPT_RATE_HI 1
`define WDCM_OPT_CM_EN 2
`define WDCM_TST_INHIBIT 0
`define WDCM_STS_CAUSE_LSB 0
`define WDCM_STS_ARMED 4
`define WDCM_STS_WD_ACTIVE 5
`define WDCM_STS_SPECIAL 6
`define WDCM_STS_RATE_DONE 7

// ========================================
// Reset values and service codes
`define WDCM_RATE_RST 2'h0
`define WDCM_CM_EN_RST 1'h0
`define WDCM_CODE_ARM 8'h55
`define WDCM_CODE_CLEAR 8'hAA

// ========================================
// Timing counts in bus cycles; prescaler width in bits
`define WDCM_PRESCALE_BITS 15
`define WDCM_RATE_WINDOW 64
`define WDCM_DRIVE_CYCLES 4
`define WDCM_SAMPLE_DELAY 2
`define WDCM_SYNC_STAGES 2

`endif

// File: logic/wdcm_pkg.sv
`default_nettype none

package wdcm_pkg;

    // ========================================
    // Reset sequencer states
    typedef enum logic [1:0] {
        WDCM_RUN,
        WDCM_DRIVE,
        WDCM_WAIT,
        WDCM_HOLD
    } wdcm_state_t;

    // ========================================
    // One-hot reset cause report
    typedef struct packed {
        logic watchdog;
        logic clock_fail;
        logic external;
    } wdcm_cause_t;

    // ========================================
    // Reset-pin driver pair
    typedef struct packed {
        logic o;
        logic oe;
    } wdcm_pin_t;

endpackage : wdcm_pkg

`default_nettype wire

// File: logic/wdcm_top.sv
// Behaviour
// - Watchdog enable comes from the config disable input, active straight out of reset.
// - A changed config disable value only takes effect at the next device reset.
// - In special modes the reset inhibit comes up 1; writing 0 enables resets.
// - In normal modes the reset inhibit stays 0; writes of 1 are ignored.
// - Both rate select bits reset to 0, selecting the shortest timeout.
// - Watchdog is clocked by bus clock through a free 2^15 prescaler.
// - Rate select divides prescaled clock by 1, 4, 16 or 64.
// - Normal modes: rate bits take one write, only within 64 cycles of reset.
// - Writing 55h to the service register arms the clearing mechanism.
// - Writing AAh while armed clears the watchdog timer.
// - The armed state persists through any other activity until cleared.
// - Watchdog expiry with resets enabled starts a system reset.
// - A completed service clears the divider stages, not the prescaler.
// - Timeout is nominal plus zero to one prescaled period, any rate.
// - Clock monitor resets when clock edges stop within an RC delay, clocklessly.
// - Clock monitor acts only while its enable bit is set.
// - Below 10 kHz always fails, at 200 kHz or faster never fails.
// - A clock-monitor reset drives the bidirectional reset pin low.
// - Clock-monitor, watchdog and external resets are reported as distinct causes.
// - Internal reset saves cause, drives pin low four cycles, samples two later.
// - Pin still low at the sample point means cause is external.
// - Cause priority: clock monitor, then watchdog, else external.
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "wdcm_consts.svh"

module wdcm_top #(
    parameter int PRESCALE_BITS = `WDCM_PRESCALE_BITS,
    parameter int RATE_WINDOW = `WDCM_RATE_WINDOW
) (
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Straps and analog
    input wire logic watchdog_disable_cfg,
    input wire logic special_mode,
    input wire logic cm_rc_expired,
    output logic cm_rc_kick,
    // Reset pin and system reset
    input wire logic rst_pin_i,
    output wdcm_pkg::wdcm_pin_t rst_pin,
    output logic sys_reset,
    output wdcm_pkg::wdcm_cause_t reset_cause
);
    import wdcm_pkg::*;

    localparam int DRIVE_N = `WDCM_DRIVE_CYCLES;
    localparam int WAIT_N = `WDCM_SAMPLE_DELAY + `WDCM_SYNC_STAGES;

    // ========================================
    // Declarations
    logic [1:0] pin_sync;
    logic [1:0] cm_sync;
    logic pin_high;
    logic cm_fail;
    wdcm_state_t state;
    logic [2:0] seq_cnt;
    logic soft_init;
    logic wd_active;
    logic wd_active_valid;
    logic special_lat;
    logic internal_reset_inhibit;
    logic watchdog_rate_sel_hi;
    logic watchdog_rate_sel_lo;
    logic clock_monitor_enable;
    logic rate_written;
    logic [6:0] window_cnt;
    logic rate_window_open;
    logic [PRESCALE_BITS-1:0] prescaler;
    logic pre_tick;
    logic [6:0] post_cnt;
    logic [6:0] rate_div;
    logic wd_expire;
    logic armed;
    logic cm_pend;
    logic wd_pend;
    logic resets_ok;
    logic dp_write;
    logic [7:0] dp_addr;
    logic wr_service;
    logic wr_option;
    logic wr_test;
    logic addr_phase;
    logic svc_arm;
    logic svc_clear;
    logic cm_async;
    logic [31:0] next_rdata;

    // ========================================
    // Input synchronisers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_sync <= 2'h3;
            cm_sync <= 2'h0;
        end
        else if (ce)
        begin
            pin_sync <= {pin_sync[0], rst_pin_i};
            cm_sync <= {cm_sync[0], cm_rc_expired};
        end
    end

    assign pin_high = pin_sync[1];
    assign cm_fail = cm_sync[1];

    // ========================================
    // Bus slave
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign addr_phase = hsel && htrans[1] && hready && ce;
    assign wr_service = dp_write && ce && (dp_addr == `WDCM_OFF_SERVICE);
    assign wr_option = dp_write && ce && (dp_addr == `WDCM_OFF_OPTION);
    assign wr_test = dp_write && ce && (dp_addr == `WDCM_OFF_TEST);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end
        else if (ce)
        begin
            dp_write <= addr_phase && hwrite;
            dp_addr <= haddr;
        end
    end

    always_comb
    begin
        next_rdata = 32'h0;
        case (haddr)
            `WDCM_OFF_OPTION:
            begin
                next_rdata[`WDCM_OPT_RATE_LO] = watchdog_rate_sel_lo;
                next_rdata[`WDCM_OPT_RATE_HI] = watchdog_rate_sel_hi;
                next_rdata[`WDCM_OPT_CM_EN] = clock_monitor_enable;
            end
            `WDCM_OFF_TEST:
                next_rdata[`WDCM_TST_INHIBIT] = internal_reset_inhibit;
            `WDCM_OFF_STATUS:
            begin
                next_rdata[`WDCM_STS_CAUSE_LSB +: 3] = reset_cause;
                next_rdata[`WDCM_STS_ARMED] = armed;
                next_rdata[`WDCM_STS_WD_ACTIVE] = wd_active;
                next_rdata[`WDCM_STS_SPECIAL] = special_lat;
                next_rdata[`WDCM_STS_RATE_DONE] = rate_written || !rate_window_open;
            end
            default:
                next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0;
        else if (addr_phase && !hwrite)
            hrdata <= next_rdata;
    end

    // ========================================
    // Strap capture at reset release and sequence end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wd_active <= 1'b0;
            special_lat <= 1'b0;
        end
        else if (ce && (soft_init || !wd_active_valid))
        begin
            wd_active <= !watchdog_disable_cfg;
            special_lat <= special_mode;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wd_active_valid <= 1'b0;
        else if (ce)
            wd_active_valid <= 1'b1;
    end

    // ========================================
    // Option and test bits
    assign rate_window_open = (window_cnt < 7'(RATE_WINDOW));
    assign resets_ok = !internal_reset_inhibit;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            window_cnt <= 7'h00;
        else if (ce)
        begin
            if (soft_init)
                window_cnt <= 7'h00;
            else if (rate_window_open)
                window_cnt <= window_cnt + 7'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            watchdog_rate_sel_hi <= 1'(`WDCM_RATE_RST >> 1);
            watchdog_rate_sel_lo <= 1'(`WDCM_RATE_RST);
            rate_written <= 1'b0;
            clock_monitor_enable <= `WDCM_CM_EN_RST;
        end
        else if (ce)
        begin
            if (soft_init)
            begin
                watchdog_rate_sel_hi <= 1'(`WDCM_RATE_RST >> 1);
                watchdog_rate_sel_lo <= 1'(`WDCM_RATE_RST);
                rate_written <= 1'b0;
                clock_monitor_enable <= `WDCM_CM_EN_RST;
            end
            else if (wr_option)
            begin
                clock_monitor_enable <= hwdata[`WDCM_OPT_CM_EN];
                if (wd_active_valid && (special_lat || (rate_window_open && !rate_written)))
                begin
                    watchdog_rate_sel_hi <= hwdata[`WDCM_OPT_RATE_HI];
                    watchdog_rate_sel_lo <= hwdata[`WDCM_OPT_RATE_LO];
                    rate_written <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            internal_reset_inhibit <= 1'b0;
        else if (ce)
        begin
            if (!wd_active_valid || soft_init)
                internal_reset_inhibit <= special_mode;
            else if (!special_lat)
                internal_reset_inhibit <= 1'b0;
            else if (wr_test)
                internal_reset_inhibit <= hwdata[`WDCM_TST_INHIBIT];
        end
    end

    // ========================================
    // Prescaler and watchdog divider
    assign pre_tick = (prescaler == {PRESCALE_BITS{1'b1}});

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            prescaler <= '0;
        else if (ce)
            prescaler <= prescaler + 1'b1;
    end

    always_comb
    begin
        case ({watchdog_rate_sel_hi, watchdog_rate_sel_lo})
            2'h0: rate_div = 7'h01;
            2'h1: rate_div = 7'h04;
            2'h2: rate_div = 7'h10;
            2'h3: rate_div = 7'h40;
            default: rate_div = 7'h01;
        endcase
    end

    assign svc_arm = wr_service && (hwdata[7:0] == `WDCM_CODE_ARM);
    assign svc_clear = wr_service && (hwdata[7:0] == `WDCM_CODE_CLEAR) && armed;
    assign wd_expire = wd_active && pre_tick && (post_cnt >= rate_div);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            post_cnt <= 7'h00;
        else if (ce)
        begin
            if (svc_clear || soft_init || state != WDCM_RUN)
                post_cnt <= 7'h00;
            else if (wd_expire)
                post_cnt <= 7'h00;
            else if (wd_active && pre_tick)
                post_cnt <= post_cnt + 7'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            armed <= 1'b0;
        else if (ce)
        begin
            if (soft_init)
                armed <= 1'b0;
            else if (svc_arm)
                armed <= 1'b1;
            else if (svc_clear)
                armed <= 1'b0;
        end
    end

    // ========================================
    // Clock monitor
    assign cm_async = clock_monitor_enable && resets_ok && cm_rc_expired;
    assign cm_rc_kick = prescaler[0];

    // ========================================
    // Reset sequencer
    assign soft_init = ce && (state == WDCM_HOLD) && pin_high;
    assign sys_reset = (state != WDCM_RUN);
    assign rst_pin.o = 1'b0;
    assign rst_pin.oe = (state == WDCM_DRIVE) || cm_async;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= WDCM_RUN;
            seq_cnt <= 3'h0;
            cm_pend <= 1'b0;
            wd_pend <= 1'b0;
        end
        else if (ce)
        begin
            case (state)
                WDCM_RUN:
                begin
                    seq_cnt <= 3'h0;
                    if (clock_monitor_enable && resets_ok && cm_fail)
                    begin
                        cm_pend <= 1'b1;
                        state <= WDCM_DRIVE;
                    end
                    else if (wd_expire && resets_ok)
                    begin
                        wd_pend <= 1'b1;
                        state <= WDCM_DRIVE;
                    end
                    else if (!pin_high)
                        state <= WDCM_DRIVE;
                end
                WDCM_DRIVE:
                begin
                    seq_cnt <= seq_cnt + 3'h1;
                    if (seq_cnt == 3'(DRIVE_N - 1))
                    begin
                        seq_cnt <= 3'h0;
                        state <= WDCM_WAIT;
                    end
                end
                WDCM_WAIT:
                begin
                    seq_cnt <= seq_cnt + 3'h1;
                    if (seq_cnt == 3'(WAIT_N - 1))
                    begin
                        cm_pend <= 1'b0;
                        wd_pend <= 1'b0;
                        state <= WDCM_HOLD;
                    end
                end
                WDCM_HOLD:
                    if (pin_high)
                        state <= WDCM_RUN;
                default:
                    state <= WDCM_RUN;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            reset_cause <= 3'h1;
        else if (ce && state == WDCM_WAIT && seq_cnt == 3'(WAIT_N - 1))
        begin
            if (!pin_high)
                reset_cause <= 3'h1;
            else if (cm_pend)
                reset_cause <= 3'h2;
            else if (wd_pend)
                reset_cause <= 3'h4;
            else
                reset_cause <= 3'h1;
        end
    end

    // ========================================
    // Checks
    sequence s_drive_run;
        rst_pin.oe [*4] ##1 (state == WDCM_WAIT);
    endsequence

    AST_ARM: assert property (@(posedge hclk) disable iff (!hresetn)
        svc_arm && !soft_init |=> armed) else $error("Arm write did not arm");
    AST_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        svc_clear |=> post_cnt == 7'h00 && !armed) else $error("Clear did not clear");
    AST_NO_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && wr_service && hwdata[7:0] == `WDCM_CODE_CLEAR && !armed && !pre_tick
        && state == WDCM_RUN && !soft_init |=> $stable(post_cnt))
        else $error("Unarmed clear changed timer");
    AST_OTHER: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_service && !svc_arm && !svc_clear && !soft_init |=> $stable(armed))
        else $error("Other value changed armed state");
    AST_NORMAL_INHIBIT: assert property (@(posedge hclk) disable iff (!hresetn)
        wd_active_valid && !special_lat && !soft_init |=> !internal_reset_inhibit)
        else $error("Inhibit set in normal mode");
    AST_RATE_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_option && !special_lat && !rate_window_open && !soft_init
        |=> $stable({watchdog_rate_sel_hi, watchdog_rate_sel_lo}))
        else $error("Late rate write accepted");
    AST_EXPIRE: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && state == WDCM_RUN && wd_expire && resets_ok |=> state == WDCM_DRIVE)
        else $error("Expiry did not start reset");
    AST_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        $rose(state == WDCM_DRIVE) && !cm_async |-> s_drive_run)
        else $error("Pin drive length wrong");
    AST_PRESCALE: assert property (@(posedge hclk) disable iff (!hresetn)
        svc_clear |=> prescaler == $past(prescaler) + 1'b1)
        else $error("Service touched prescaler");
    AST_CM_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        !clock_monitor_enable && state != WDCM_DRIVE |-> !rst_pin.oe)
        else $error("Monitor drove pin while off");

endmodule : wdcm_top

`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "wdcm_consts.svh"

module tb_top;
    import wdcm_pkg::*;

    localparam logic [7:0] SVC = `WDCM_OFF_SERVICE;
    localparam logic [7:0] OPT = `WDCM_OFF_OPTION;
    localparam logic [7:0] TST = `WDCM_OFF_TEST;
    localparam logic [7:0] STS = `WDCM_OFF_STATUS;

    logic hclk = 1'b0;
    logic clk_run = 1'b1;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic cfg_off = 1'b1;
    logic special = 1'b0;
    logic ext_low = 1'b0;
    logic rc_exp;
    logic kick;
    logic pin_lvl;
    wdcm_pin_t rst_pin;
    logic sys_reset;
    wdcm_cause_t reset_cause;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;

    // ========================================
    // Clock, bus loop-back, instances
    always #25 hclk = clk_run ? ~hclk : hclk;
    always @(posedge hclk) cyc <= cyc + 1;
    assign hready = hreadyout;

    wdcm_top #(.PRESCALE_BITS(4), .RATE_WINDOW(64)) dut (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .watchdog_disable_cfg(cfg_off), .special_mode(special),
        .cm_rc_expired(rc_exp), .cm_rc_kick(kick), .rst_pin_i(pin_lvl),
        .rst_pin(rst_pin), .sys_reset(sys_reset), .reset_cause(reset_cause));

    wdcm_far_model #(.RC_NS(2000)) far (
        .pin_oe(rst_pin.oe), .pin_o(rst_pin.o), .ext_low(ext_low),
        .pin_level(pin_lvl), .rc_kick(kick), .rc_expired(rc_exp));

    // ========================================
    // Reporting
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic give_up();
        bad_count++;
        $display("Wait limit reached at %0t", $time);
        test_done();
    endtask : give_up

    // ========================================
    // Bus master
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1)
        begin
            if (++n > 50)
                give_up();
            @(posedge hclk);
        end
    endtask : wait_ready

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        bus(a, 1'b0, 32'h0, r);
    endtask : rd

    task automatic service();
        wr(SVC, 32'h55);
        wr(SVC, 32'hAA);
    endtask : service

    // ========================================
    // Reset helpers
    task automatic hard_reset(input logic c, input logic s);
        @(posedge hclk);
        hresetn <= 1'b0;
        cfg_off <= c;
        special <= s;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask : hard_reset

    task automatic wait_sr(input logic v, input int lim);
        int n;
        n = 0;
        do
        begin
            @(negedge hclk);
            if (++n > lim)
                give_up();
        end
        while (sys_reset !== v);
    endtask : wait_sr

    task automatic seq_end(output int k);
        int n;
        n = 0;
        k = 0;
        while (sys_reset === 1'b1)
        begin
            if (rst_pin.oe === 1'b1)
                k++;
            @(negedge hclk);
            if (++n > 500)
                give_up();
        end
    endtask : seq_end

    // ========================================
    // Scenarios
    task automatic t_reset_vals();
        logic [31:0] v;
        rd(STS, v);
        check(v & 32'hFF, 32'h01);
        rd(OPT, v);
        check(v, 32'h0);
        wr(TST, 32'h1);
        rd(TST, v);
        check(v & 32'h1, 32'h0);
        rd(8'h10, v);
        check(v, 32'h0);
        cfg_off <= 1'b0;
        repeat (100) @(negedge hclk);
        check({31'h0, sys_reset}, 32'h0);
        rd(STS, v);
        check(v & 32'h20, 32'h0);
        wr(OPT, 32'h3);
        rd(OPT, v);
        check(v & 32'h3, 32'h0);
        cfg_off <= 1'b1;
        $display("Reset values test done");
    endtask : t_reset_vals

    task automatic t_cm(input logic en);
        int k;
        wr(OPT, {29'h0, en, 2'h0});
        @(negedge hclk);
        clk_run = 1'b0;
        #10000;
        check({31'h0, rst_pin.oe}, {31'h0, en});
        check({31'h0, pin_lvl}, {31'h0, !en});
        clk_run = 1'b1;
        if (en)
        begin
            wait_sr(1'b1, 300);
            seq_end(k);
            check({29'h0, reset_cause}, 32'h2);
        end
        else
        begin
            repeat (30) @(negedge hclk);
            check({31'h0, sys_reset}, 32'h0);
        end
        $display("Clock monitor test done");
    endtask : t_cm

    task automatic t_wd(input int r);
        int k;
        int dv;
        int t0;
        int el;
        logic [31:0] v;
        dv = 1 << (2 * r);
        hard_reset(1'b0, 1'b0);
        wr(OPT, 32'(r));
        service();
        t0 = cyc;
        if (r == 3)
        begin
            wr(OPT, 32'h0);
            rd(OPT, v);
            check(v & 32'h3, 32'h3);
            repeat (500) @(posedge hclk);
            wr(SVC, 32'hAA);
            wr(SVC, 32'h12);
            wr(SVC, 32'h55);
            wr(SVC, 32'h12);
            rd(STS, v);
            check(v & 32'h10, 32'h10);
        end
        wait_sr(1'b1, 1100);
        el = cyc - t0;
        check(32'(el > dv * 16 && el <= (dv + 1) * 16 + 1), 32'h1);
        seq_end(k);
        check(32'(k), 32'h4);
        check({29'h0, reset_cause}, 32'h4);
        rd(OPT, v);
        check(v & 32'h7, 32'h0);
        $display("Watchdog rate test done");
    endtask : t_wd

    task automatic t_ext();
        hard_reset(1'b0, 1'b0);
        wait_sr(1'b1, 100);
        ext_low <= 1'b1;
        repeat (20) @(negedge hclk);
        ext_low <= 1'b0;
        wait_sr(1'b0, 200);
        check({29'h0, reset_cause}, 32'h1);
        $display("External reset test done");
    endtask : t_ext

    task automatic t_special();
        int k;
        logic [31:0] v;
        hard_reset(1'b0, 1'b1);
        rd(TST, v);
        check(v & 32'h1, 32'h1);
        repeat (60) @(negedge hclk);
        check({31'h0, sys_reset}, 32'h0);
        wr(TST, 32'h0);
        wait_sr(1'b1, 40);
        seq_end(k);
        check({29'h0, reset_cause}, 32'h4);
        @(posedge hclk);
        special <= 1'b0;
        $display("Special mode test done");
    endtask : t_special

    // ========================================
    // Main sequence
    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_reset_vals();
        t_cm(1'b1);
        t_cm(1'b0);
        for (int r = 0; r < 4; r++)
            t_wd(r);
        t_ext();
        t_special();
        test_done();
    end
endmodule : tb_top

`default_nettype wire

// File: test/wdcm_far_model.sv
`timescale 1ns/100ps
`default_nettype none

module wdcm_far_model #(
    parameter int RC_NS = 2000
) (
    // Reset pin
    input wire logic pin_oe,
    input wire logic pin_o,
    input wire logic ext_low,
    output logic pin_level,
    // RC delay cell
    input wire logic rc_kick,
    output logic rc_expired
);
    localparam int RECHARGE_KICKS = 2;
    realtime last_kick = 0.0;
    int kick_count = 0;
    int count_at_fail = 0;
    logic timed_out = 1'b0;

    // ========================================
    // Open-drain pin with pull-up
    assign pin_level = ((pin_oe === 1'b1 && pin_o !== 1'b1) || ext_low) ? 1'b0 : 1'b1;

    // ========================================
    // RC cell, recharged by kick edges
    assign rc_expired = timed_out && (kick_count - count_at_fail < RECHARGE_KICKS);

    always @(rc_kick)
    begin
        last_kick = $realtime;
        kick_count++;
    end

    always #100
    begin
        if ($realtime - last_kick > RC_NS)
        begin
            timed_out = 1'b1;
            count_at_fail = kick_count;
        end
        else if (kick_count - count_at_fail >= RECHARGE_KICKS)
            timed_out = 1'b0;
    end
endmodule : wdcm_far_model

`default_nettype wire
